/* rtl/dotd_pkg.sv */
package dotd_pkg;
    // ==========================================
    // Register map
    // ==========================================
    localparam logic [3:0] ADDR_CTRL      = 4'h0;  // Latch controls and head number
    localparam logic [3:0] ADDR_STATUS    = 4'h1;  // Live block state
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h2;  // Sticky event bits
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'h3;  // Event enables
    localparam logic [3:0] ADDR_SECTOR    = 4'h4;  // Saved sector register
    // ==========================================
    // Control field positions
    // ==========================================
    localparam int CTRL_DIAG1     = 0;   // Diagnostic-1 latch
    localparam int CTRL_SEL_LOCK  = 1;   // Select-lock latch
    localparam int CTRL_DEV_CHECK = 2;   // Device check
    localparam int CTRL_HEAD_LSB  = 8;   // Head number field low bit
    // ==========================================
    // Interrupt bit positions
    // ==========================================
    localparam int IRQ_REJECT     = 0;   // Command reject raised
    localparam int IRQ_SAVED      = 1;   // Sector register loaded
    localparam int IRQ_AM_WRITE   = 2;   // Address mark write started
    // ==========================================
    // Reset values and timing
    // ==========================================
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [2:0]  IRQ_RESET  = 3'h0;
    localparam logic [7:0]  SECTOR_RESET = 8'h00;
    localparam logic [7:0]  CLK_COUNT_LATE = 8'h32;  // Clock count 50
    localparam logic [7:0]  CLK_COUNT_LOAD = 8'h04;  // Clock count 4
    localparam int CLK_PERIOD_PS  = 8000;            // 125 MHz
    localparam int WF_BLOCK_NS    = 5000;            // 5.0 us fault blanking
    localparam int WF_BLOCK_CYC   = (WF_BLOCK_NS * 1000) / CLK_PERIOD_PS;
    localparam int WF_CNT_W       = 10;
endpackage

/* rtl/dotd_sync.sv */
`timescale 1ns/1ps
// ==========================================
// Two-stage synchroniser, one per bit
// ==========================================
module dotd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta;  // First stage, read only by second

    // Two flops per bit
    always_ff @(posedge clk) begin
        meta <= din;
        dout <= meta;
    end
endmodule

/* rtl/dotd_oneshot.sv */
`timescale 1ns/1ps
// ==========================================
// Retriggerable fixed-length delay
// ==========================================
module dotd_oneshot (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic fire,
    output logic      active
);
    localparam logic [dotd_pkg::WF_CNT_W-1:0] LEN =
        dotd_pkg::WF_CNT_W'(dotd_pkg::WF_BLOCK_CYC);
    logic [dotd_pkg::WF_CNT_W-1:0] count;  // Cycles left

    // Load on fire, count down to zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (fire) begin
            count <= LEN;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign active = (count != '0);
endmodule

/* rtl/dotd_top.sv */
`timescale 1ns/1ps
// How it works
// RULE1: Tag 10 drives diff and reverse inbound
// RULE2: Command valid needs select, not parity
// RULE3: Operate valid needs all six conditions
// RULE4: Controller holds outbound bits until done
// RULE5: Impossible operate raises command reject
// RULE6: Decode outbound bits 0-7 under operate
// RULE7: Head select uses head number register
// RULE8: Bits 0,3,5 write mark, controller-timed
// RULE9: Mark write fires write-fault blanking delay
// RULE10: Bit0 starts mark, bit5 enables write
// RULE11: Bit1 starts mark search during read
// RULE12: Controller reads until three silent bytes
// RULE13: Before count 50 save sector now
// RULE14: After count 50 save at count 4
module dotd_top (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    // Controller pins
    input  wire logic        unit_selected,
    input  wire logic        tag10,
    input  wire logic        tag11,
    input  wire logic [7:0]  outbound_bus_bit,
    output logic      [7:0]  inbound_bus_bit,
    output logic             command_reject,
    // Drive-side state
    input  wire logic        on_cylinder,
    input  wire logic        diff_512,
    input  wire logic        diff_256,
    input  wire logic        reverse_dir,
    input  wire logic        write_fault_raw,
    input  wire logic [7:0]  sector_counter,
    input  wire logic [7:0]  clock_count,
    // Decoded operation lines
    output logic             operate_valid,
    output logic             start_write_mark,
    output logic             mark_search,
    output logic             data_enable,
    output logic [7:0]       head_select,
    output logic             head_advance,
    output logic             write_enable,
    output logic             read_select,
    output logic             write_fault
);
    // ==========================================
    // Input synchronisers
    // ==========================================
    logic [7:0]  bob_s;       // Outbound bus, synced
    logic [7:0]  sec_cnt_s;   // Sector counter, synced
    logic [7:0]  clk_cnt_s;   // Clock count, synced
    logic [7:0]  misc_s;      // Loose pins, synced
    logic        sel_s;       // Unit selected
    logic        t10_s;       // Tag 10
    logic        t11_s;       // Tag 11
    logic        oncyl_s;     // On cylinder
    logic        d512_s;      // Difference 512
    logic        d256_s;      // Difference 256
    logic        rev_s;       // Reverse direction
    logic        wf_s;        // Raw write fault

    // Every pin input passes two flops
    dotd_sync #(.W(8)) u_sync_bob (
        .clk  (clk),
        .din  (outbound_bus_bit),
        .dout (bob_s)
    );
    dotd_sync #(.W(8)) u_sync_sec (
        .clk  (clk),
        .din  (sector_counter),
        .dout (sec_cnt_s)
    );
    dotd_sync #(.W(8)) u_sync_clk (
        .clk  (clk),
        .din  (clock_count),
        .dout (clk_cnt_s)
    );
    dotd_sync #(.W(8)) u_sync_misc (
        .clk  (clk),
        .din  ({unit_selected, tag10, tag11, on_cylinder,
                diff_512, diff_256, reverse_dir, write_fault_raw}),
        .dout (misc_s)
    );
    assign {sel_s, t10_s, t11_s, oncyl_s, d512_s, d256_s, rev_s, wf_s} = misc_s;

    // ==========================================
    // Software registers
    // ==========================================
    logic [31:0] ctrl;        // Latches and head number
    logic [2:0]  irq_stat;    // Sticky events
    logic [2:0]  irq_mask;    // Event enables
    logic [7:0]  sector_reg;  // Saved sector
    logic [2:0]  irq_evt;     // Event pulses this cycle
    logic [2:0]  head_num;    // Head number register

    assign head_num = ctrl[dotd_pkg::CTRL_HEAD_LSB +: 3];

    // Control register write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= dotd_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == dotd_pkg::ADDR_CTRL) begin
            ctrl <= reg_wdata;
        end
    end

    // Mask register write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_mask <= dotd_pkg::IRQ_RESET;
        end else if (reg_wr && reg_addr == dotd_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= reg_wdata[2:0];
        end
    end

    // Sticky status: set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_stat <= dotd_pkg::IRQ_RESET;
        end else if (reg_wr && reg_addr == dotd_pkg::ADDR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~reg_wdata[2:0]) | irq_evt;
        end else begin
            irq_stat <= irq_stat | irq_evt;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==========================================
    // Command validation
    // ==========================================
    logic cmd_valid;   // Tag 11 with unit selected
    logic op_valid;    // Full operate qualification
    logic op_reject;   // Tag 11 that cannot run

    // Selection alone qualifies, parity ignored
    assign cmd_valid = t11_s && sel_s;  // [RULE2]
    // All six conditions together
    assign op_valid = !ctrl[dotd_pkg::CTRL_DEV_CHECK] && !ctrl[dotd_pkg::CTRL_DIAG1]
                   && !ctrl[dotd_pkg::CTRL_SEL_LOCK] && oncyl_s
                   && cmd_valid && t11_s;  // [RULE3]
    // Selected tag 11 that fails qualification
    assign op_reject = cmd_valid && !op_valid;

    // Registered decode outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            operate_valid  <= 1'b0;
            command_reject <= 1'b0;
        end else begin
            operate_valid  <= op_valid;
            command_reject <= op_reject;  // [RULE5]
        end
    end

    // ==========================================
    // Tag 10 status onto inbound bus
    // ==========================================
    // Gated regardless of operate qualification
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            inbound_bus_bit <= 8'h00;
        end else if (t10_s) begin
            inbound_bus_bit <= {3'h0, rev_s, 2'h0, d256_s, d512_s};  // [RULE1]
        end else begin
            inbound_bus_bit <= 8'h00;
        end
    end

    // ==========================================
    // Outbound bit decode
    // ==========================================
    // Lines follow the held bus bits while valid
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start_write_mark <= 1'b0;
            mark_search      <= 1'b0;
            data_enable      <= 1'b0;
            head_select      <= 8'h00;
            head_advance     <= 1'b0;
            write_enable     <= 1'b0;
            read_select      <= 1'b0;
        end else begin
            // Controller keeps bits until done [RULE4]
            start_write_mark <= op_valid && bob_s[0];       // [RULE6] [RULE10]
            mark_search      <= op_valid && bob_s[1];       // [RULE6] [RULE11]
            data_enable      <= op_valid && bob_s[2];       // [RULE6]
            head_select      <= (op_valid && bob_s[3]) ? (8'h01 << head_num)
                                                       : 8'h00;  // [RULE7]
            head_advance     <= op_valid && bob_s[4];       // [RULE6]
            write_enable     <= op_valid && bob_s[5];       // [RULE6] [RULE10]
            read_select      <= op_valid && bob_s[6];       // [RULE6]
        end
    end

    // ==========================================
    // Address mark write and fault blanking
    // ==========================================
    logic am_write;     // Bits 0, 3 and 5 together
    logic am_write_d;   // Previous cycle
    logic am_start;     // Rising edge of mark write
    logic wf_block;     // Blanking delay running

    // Length is the controller's hold time [RULE8]
    assign am_write = op_valid && bob_s[0] && bob_s[3] && bob_s[5];  // [RULE8]
    assign am_start = am_write && !am_write_d;

    // Edge history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            am_write_d <= 1'b0;
        end else begin
            am_write_d <= am_write;
        end
    end

    // Delay fired at start of the mark write
    dotd_oneshot u_wf_block (
        .clk     (clk),
        .sys_rst (sys_rst),
        .fire    (am_start),  // [RULE9]
        .active  (wf_block)
    );

    // Fault suppressed while blanking runs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            write_fault <= 1'b0;
        end else begin
            write_fault <= wf_s && !wf_block && !am_start;  // [RULE9]
        end
    end

    // ==========================================
    // Save sector
    // ==========================================
    logic save_req;      // Bit 7 under operate
    logic save_req_d;    // Previous cycle
    logic save_pending;  // Waiting for count 4
    logic save_now;      // Load this cycle

    assign save_req = op_valid && bob_s[7];
    assign save_now = (save_req && !save_req_d && clk_cnt_s < dotd_pkg::CLK_COUNT_LATE)
                   || (save_pending && clk_cnt_s == dotd_pkg::CLK_COUNT_LOAD);

    // Deferred load tracking
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            save_req_d   <= 1'b0;
            save_pending <= 1'b0;
        end else begin
            save_req_d <= save_req;
            if (save_req && !save_req_d && clk_cnt_s >= dotd_pkg::CLK_COUNT_LATE) begin
                save_pending <= 1'b1;  // [RULE14]
            end else if (save_pending && clk_cnt_s == dotd_pkg::CLK_COUNT_LOAD) begin
                save_pending <= 1'b0;  // [RULE14]
            end
        end
    end

    // Sector register load
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sector_reg <= dotd_pkg::SECTOR_RESET;
        end else if (save_now) begin
            sector_reg <= sec_cnt_s;  // [RULE13] [RULE14]
        end
    end

    // Event pulses into status
    assign irq_evt = {am_start, save_now, op_reject && !command_reject};

    // ==========================================
    // Register read port
    // ==========================================
    // Data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_addr == dotd_pkg::ADDR_CTRL) begin
            reg_rdata <= ctrl;
        end else if (reg_addr == dotd_pkg::ADDR_STATUS) begin
            reg_rdata <= {24'h0, save_pending, wf_block, mark_search,
                          write_enable, read_select, command_reject,
                          operate_valid, cmd_valid};
        end else if (reg_addr == dotd_pkg::ADDR_IRQ_STAT) begin
            reg_rdata <= {29'h0, irq_stat};
        end else if (reg_addr == dotd_pkg::ADDR_IRQ_MASK) begin
            reg_rdata <= {29'h0, irq_mask};
        end else if (reg_addr == dotd_pkg::ADDR_SECTOR) begin
            reg_rdata <= {24'h0, sector_reg};
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

/* tb/dotd_top_assertions.sv */
`timescale 1ns/1ps
// ==========================================
// Pin-level checker for the decoder
// ==========================================
module dotd_top_chk (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       unit_selected,
    input wire logic       tag10,
    input wire logic       tag11,
    input wire logic [7:0] outbound_bus_bit,
    input wire logic [7:0] inbound_bus_bit,
    input wire logic       command_reject,
    input wire logic       on_cylinder,
    input wire logic       diff_512,
    input wire logic       diff_256,
    input wire logic       reverse_dir,
    input wire logic       operate_valid,
    input wire logic       start_write_mark,
    input wire logic       mark_search,
    input wire logic       data_enable,
    input wire logic [7:0] head_select,
    input wire logic       head_advance,
    input wire logic       write_enable,
    input wire logic       read_select,
    input wire logic       write_fault
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // Properties, pins seen three edges late
    // ==========================================
    sequence s_mark_go;
        $rose(start_write_mark);
    endsequence
    property p_tag10;
        inbound_bus_bit == ($past(tag10, 3) ? {3'h0, $past(reverse_dir, 3), 2'h0,
            $past(diff_256, 3), $past(diff_512, 3)} : 8'h00);
    endproperty
    property p_op;
        operate_valid |-> $past(tag11 && unit_selected && on_cylinder, 3);
    endproperty
    property p_rej;
        command_reject |-> !operate_valid && $past(tag11 && unit_selected, 3);
    endproperty
    property p_idle;
        !$past(tag11 && unit_selected, 3) |-> !operate_valid && !command_reject;
    endproperty
    property p_dec;
        operate_valid |-> {read_select, write_enable, head_advance, data_enable, mark_search,
            start_write_mark} == {$past(outbound_bus_bit[6:4], 3), $past(outbound_bus_bit[2:0], 3)};
    endproperty
    property p_quiet;
        !operate_valid |-> !(start_write_mark || mark_search || data_enable || head_advance
            || write_enable || read_select) && head_select == 8'h00;
    endproperty
    property p_head;
        head_select != 8'h00 |-> $onehot(head_select) && $past(outbound_bus_bit[3], 3);
    endproperty
    property p_blank;
        s_mark_go |-> ##2 !write_fault [*8];
    endproperty
    a_tag10: assert property (p_tag10) else $error("inbound bits wrong");
    a_op: assert property (p_op) else $error("operate without cause");
    a_rej: assert property (p_rej) else $error("reject without tag");
    a_idle: assert property (p_idle) else $error("response without select");
    a_dec: assert property (p_dec) else $error("decode mismatch");
    a_quiet: assert property (p_quiet) else $error("decode without operate");
    a_head: assert property (p_head) else $error("head select wrong");
    a_blank: assert property (p_blank) else $error("fault not blanked");
endmodule
bind dotd_top dotd_top_chk u_chk (.clk(clk), .sys_rst(sys_rst), .unit_selected(unit_selected),
    .tag10(tag10), .tag11(tag11), .outbound_bus_bit(outbound_bus_bit),
    .inbound_bus_bit(inbound_bus_bit), .command_reject(command_reject),
    .on_cylinder(on_cylinder), .diff_512(diff_512), .diff_256(diff_256),
    .reverse_dir(reverse_dir), .operate_valid(operate_valid),
    .start_write_mark(start_write_mark), .mark_search(mark_search), .data_enable(data_enable),
    .head_select(head_select), .head_advance(head_advance), .write_enable(write_enable),
    .read_select(read_select), .write_fault(write_fault));

/* tb/dotd_ctl_model.sv */
`timescale 1ns/1ps
// ==========================================
// Controller side: bus first, then tag
// ==========================================
module dotd_ctl_model (
    input wire logic       clk,
    input wire logic       go,
    input wire logic [7:0] bits,
    output logic           tag11,
    output logic [7:0]     outbound_bus_bit
);
    logic bus_up;  // Bus already presented
    initial begin
        tag11 = 1'b0;
        bus_up = 1'b0;
        outbound_bus_bit = 8'h5a;
    end
    // Tag follows bus, bus outlasts tag, held while the operation runs
    always @(posedge clk) begin
        bus_up <= go;
        tag11 <= go && bus_up;
        if (go || tag11) begin
            outbound_bus_bit <= bits;
        end else begin
            outbound_bus_bit <= ~outbound_bus_bit;  // Released bus toggles
        end
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
    logic unit_selected = 1'b0, tag10 = 1'b0, on_cylinder = 1'b0, write_fault_raw = 1'b0;
    logic diff_512 = 1'b0, diff_256 = 1'b0, reverse_dir = 1'b0, tag11, irq, command_reject;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, st = 32'd18578, r;
    logic [7:0] sector_counter = 8'h00, clock_count = 8'h00, m_bits = 8'h00, bus, inb, hs, s;
    logic operate_valid, swm, ms, de, ha, we, rs, wf;
    logic [7:0] pats [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h29, 8'h4e};
    int fails = 0, num_checks = 0, cycles = 0;
    always #4 clk = ~clk;
    dotd_ctl_model u_ctl (.clk(clk), .go(go), .bits(m_bits), .tag11(tag11),
        .outbound_bus_bit(bus));
    dotd_top uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .unit_selected(unit_selected), .tag10(tag10), .tag11(tag11), .outbound_bus_bit(bus),
        .inbound_bus_bit(inb), .command_reject(command_reject), .on_cylinder(on_cylinder),
        .diff_512(diff_512), .diff_256(diff_256), .reverse_dir(reverse_dir),
        .write_fault_raw(write_fault_raw), .sector_counter(sector_counter),
        .clock_count(clock_count), .operate_valid(operate_valid), .start_write_mark(swm),
        .mark_search(ms), .data_enable(de), .head_select(hs), .head_advance(ha),
        .write_enable(we), .read_select(rs), .write_fault(wf));
    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    // Expected inbound word under tag 10
    function automatic logic [7:0] exp_in(input logic [31:0] v);
        return {3'h0, v[0] & v[3], 2'h0, v[0] & v[2], v[0] & v[1]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        cyc(1);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        cyc(1);
        reg_rd <= 1'b0;
        chk("reg_rdata", e, reg_rdata);
    endtask
    task automatic op(input logic [7:0] b, input logic g);
        @(posedge clk);
        m_bits <= b; go <= g;
        cyc(g ? 8 : 6);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        cyc(4);
        sys_rst <= 1'b0;
        rd(dotd_pkg::ADDR_CTRL, 32'h0); rd(dotd_pkg::ADDR_SECTOR, 32'h0); rd(4'hf, 32'h0);
        wr(dotd_pkg::ADDR_IRQ_MASK, 32'h7);
        rd(dotd_pkg::ADDR_IRQ_MASK, 32'h7);
        // Tag 10 status word with random drive state
        for (int i = 0; i < 8; i++) begin
            r = xs();
            @(posedge clk);
            tag10 <= r[0]; diff_512 <= r[1]; diff_256 <= r[2]; reverse_dir <= r[3];
            cyc(5);
            chk("inbound", exp_in(r), inb);
        end
        // Qualification: ok, diag1, lock, check, off cylinder, unselected
        for (int i = 0; i < 6; i++) begin
            wr(dotd_pkg::ADDR_CTRL, (i >= 1 && i <= 3) ? 32'h1 << (i - 1) : 32'h0);
            @(posedge clk);
            on_cylinder <= (i != 4); unit_selected <= (i != 5);
            op(8'h00, 1'b1);
            chk("operate_valid", i == 0, operate_valid);
            chk("command_reject", i >= 1 && i <= 4, command_reject);
            chk("irq", i >= 1 && i <= 4, irq);
            op(8'h00, 1'b0);
            wr(dotd_pkg::ADDR_IRQ_STAT, 32'h7);
            chk("irq_clear", 1'b0, irq);
        end
        // Bus bit decode, singles and composites
        @(posedge clk);
        unit_selected <= 1'b1;  // Selection back on after the unselected case
        for (int i = 0; i < 9; i++) begin
            r = xs() % 8;
            wr(dotd_pkg::ADDR_CTRL, r << dotd_pkg::CTRL_HEAD_LSB);
            op(pats[i], 1'b1);
            chk("decode", {pats[i][6:4], pats[i][2:0]}, {rs, we, ha, de, ms, swm});
            chk("head_select", pats[i][3] ? 8'h1 << r : 8'h0, hs);
            op(pats[i], 1'b0);
        end
        wr(dotd_pkg::ADDR_IRQ_STAT, 32'h7);
        // Mark write blanks a standing write fault for 625 cycles
        write_fault_raw <= 1'b1;
        op(8'h29, 1'b1);
        cyc(20);
        chk("write_fault_blanked", 1'b0, wf);
        rd(dotd_pkg::ADDR_IRQ_STAT, 32'h4);
        cyc(650);
        chk("write_fault_after", 1'b1, wf);
        op(8'h29, 1'b0);
        write_fault_raw <= 1'b0;
        // Save sector at count 49 loads at once
        r = xs();
        s = r[7:0];
        sector_counter <= s; clock_count <= 8'h31;
        op(8'h80, 1'b1);
        rd(dotd_pkg::ADDR_SECTOR, s);
        op(8'h80, 1'b0);
        // At count 50 the load waits for count 4
        clock_count <= 8'h32; sector_counter <= s + 8'h11;
        op(8'h80, 1'b1);
        rd(dotd_pkg::ADDR_SECTOR, s);
        rd(dotd_pkg::ADDR_STATUS, 32'h83);
        sector_counter <= s + 8'h22; clock_count <= 8'h04;
        cyc(6);
        rd(dotd_pkg::ADDR_SECTOR, 8'(s + 8'h22));
        op(8'h80, 1'b0);
        print_verdict();
    end
endmodule
